//--- rtl/prpo_core.sv
// macrocell register array with power-up clear, preload and observe test modes
// assumes a tester drives test_i/preload_i and the pins synchronously to mclk_i
//
// Operation
// - power-up clears every flip-flop low
// - outputs after clear follow programmed polarity; plain combinatorial cells show their live terms instead
// - clear completes within ten microseconds
// - preload writes flip-flops from pin values
// - observe forces output buffers on
// - asserted clear/set terms overwrite preloaded values
// - test forces registered mode, terms zero
// - combinatorial outputs recover after test
// - combinatorial latch content lost in test
`timescale 1ns/1ps
module prpo_core
  import prpo_pkg::*;
#(
  parameter int NCELL = PRPO_NCELL_DEF
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic test_i,
  input wire logic preload_i,
  input wire logic [NCELL-1:0] pterm_i,
  input wire logic [NCELL-1:0] pol_cfg_i,
  input wire logic [NCELL-1:0] comb_cfg_i,
  input wire logic [NCELL-1:0] latch_cfg_i,
  input wire logic [NCELL-1:0] oe_cfg_i,
  input wire logic [NCELL-1:0] clr_src_i,
  input wire logic [NCELL-1:0] clr_dst_i,
  input wire logic [NCELL-1:0] set_src_i,
  input wire logic [NCELL-1:0] set_dst_i,
  input wire logic [NCELL-1:0] io_i,
  output logic [NCELL-1:0] io_o,
  output logic [NCELL-1:0] io_oe_n_o,
  output logic [NCELL-1:0] lat_o,
  output logic ready_o,
  output logic test_act_o
);
  ////////////////////////////////////////////////////////////////////////////
  // elaboration check: NCELL must lie between 1 and PRPO_NCELL_MAX
  if (NCELL < 1 || NCELL > PRPO_NCELL_MAX) begin : g_chk
    $error("prpo_core: NCELL out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  prpo_state_t state_reg; // operating state
  prpo_state_t state_next;
  logic [NCELL-1:0] mc_reg; // macrocell flip-flops
  logic [NCELL-1:0] mc_next;
  logic [NCELL-1:0] lat_reg; // combinatorial latch value, reloaded from the terms each cycle
  logic [NCELL-1:0] lat_next;
  logic [NCELL-1:0] out_reg; // pin data, registered
  logic [NCELL-1:0] out_next;
  logic [NCELL-1:0] oen_reg; // pin enables, active low, registered
  logic [NCELL-1:0] oen_next;
  logic [NCELL-1:0] pt; // product terms after test forcing
  logic clr_hit; // clear term asserted by the register contents
  logic set_hit; // preset term asserted by the register contents

  prpo_tmr_if tmr_if ();

  assign tmr_if.ce = ce_i;

  // power-up window timer
  prpo_pur_timer u_tmr (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .tmr(tmr_if)
  );

  // or of selected register bits, shared by the clear and preset terms
  function automatic logic term_hit(input logic [NCELL-1:0] q, input logic [NCELL-1:0] sel);
    term_hit = |(q & sel);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PRPO_ST_PUR: begin
        if (tmr_if.done) begin
          state_next = PRPO_ST_RUN;
        end
      end
      PRPO_ST_RUN: begin
        if (test_i) begin
          state_next = PRPO_ST_TEST;
        end
      end
      PRPO_ST_TEST: begin
        if (!test_i) begin
          state_next = PRPO_ST_RUN;
        end
      end
      default: begin
        state_next = PRPO_ST_PUR;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register and latch next values
  always_comb begin
    pt = (state_reg == PRPO_ST_TEST) ? '0 : pterm_i;
    clr_hit = term_hit(mc_reg, clr_src_i);
    set_hit = term_hit(mc_reg, set_src_i);
    mc_next = mc_reg;
    // latch lost in test
    // the latch only follows the terms, so zeroed terms wipe it during test
    lat_next = pt;
    case (state_reg)
      PRPO_ST_PUR: begin
        mc_next = {NCELL{PRPO_REG_RST}};
        lat_next = {NCELL{PRPO_REG_RST}};
      end
      // normal clocking from product terms
      PRPO_ST_RUN: begin
        mc_next = pterm_i;
      end
      PRPO_ST_TEST: begin
        if (preload_i) begin
          mc_next = io_i;
        end
      end
      default: begin
        mc_next = {NCELL{PRPO_REG_RST}};
      end
    endcase
    if (state_reg != PRPO_ST_PUR) begin
      if (clr_hit) begin
        mc_next = mc_next & ~clr_dst_i;
      end
      if (set_hit) begin
        mc_next = mc_next | set_dst_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin data and enables, taken from the next state so pins track registers
  always_comb begin
    // polarity over register or live terms
    if (state_next == PRPO_ST_RUN) begin
      out_next = pol_cfg_i ^ ((comb_cfg_i & ~latch_cfg_i & pterm_i)
        | (comb_cfg_i & latch_cfg_i & lat_next) | (~comb_cfg_i & mc_next));
    end else begin
      // registered view only in test and clear
      out_next = pol_cfg_i ^ mc_next;
    end
    // observe overrides enables; preload releases pins
    if (state_next == PRPO_ST_TEST) begin
      oen_next = preload_i ? '1 : '0;
    end else begin
      oen_next = ~oe_cfg_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers only; the clock enable freezes everything except the power-detect reset
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg <= PRPO_ST_PUR;
      mc_reg <= '0;
      lat_reg <= '0;
      out_reg <= '0;
      oen_reg <= '1;
    end else if (ce_i) begin
      state_reg <= state_next;
      mc_reg <= mc_next;
      lat_reg <= lat_next;
      out_reg <= out_next;
      oen_reg <= oen_next;
    end
  end

  assign io_o = out_reg;
  assign io_oe_n_o = oen_reg;
  assign lat_o = lat_reg;
  assign ready_o = (state_reg == PRPO_ST_RUN);
  assign test_act_o = (state_reg == PRPO_ST_TEST);

  ////////////////////////////////////////////////////////////////////////////
  // checking helpers
  logic [PRPO_CNT_W:0] pur_cnt_reg; // cycles seen in the clear state
  logic [NCELL-1:0] comb_exp; // expected plain-combinatorial pin values
  logic [NCELL-1:0] comb_msk; // plain combinatorial cells

  assign comb_exp = pol_cfg_i ^ pterm_i;
  assign comb_msk = comb_cfg_i & ~latch_cfg_i;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pur_cnt_reg <= '0;
    end else if (ce_i && state_reg == PRPO_ST_PUR) begin
      pur_cnt_reg <= pur_cnt_reg + (PRPO_CNT_W + 1)'(1);
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  pur_clear_a: assert property (
    (state_reg == PRPO_ST_PUR) |-> (mc_reg == '0 && lat_reg == '0))
    else $error("flip-flops not clear during power-up");

  // plain combinatorial cells may already show live terms on the exit edge
  pur_polarity_a: assert property (
    (ce_i && state_reg == PRPO_ST_PUR)
    |=> (((io_o ^ $past(pol_cfg_i)) & ~$past(comb_msk)) == '0))
    else $error("pin level does not follow polarity after clear");

  pur_time_a: assert property (
    pur_cnt_reg <= (PRPO_CNT_W + 1)'(PRPO_PR_CYC))
    else $error("power-up clear overran its window");

  preload_write_a: assert property (
    (ce_i && state_reg == PRPO_ST_TEST && preload_i && !clr_hit && !set_hit)
    |=> (mc_reg == $past(io_i)))
    else $error("preload did not load pin values");

  observe_drive_a: assert property (
    (ce_i && test_i && !preload_i && state_reg != PRPO_ST_PUR) |=> (io_oe_n_o == '0))
    else $error("observe did not enable all outputs");

  async_clear_a: assert property (
    (ce_i && state_reg != PRPO_ST_PUR && clr_hit && !set_hit)
    |=> ((mc_reg & $past(clr_dst_i)) == '0))
    else $error("clear term did not overwrite registers");

  test_terms_a: assert property (
    (state_reg == PRPO_ST_TEST) |-> (pt == '0))
    else $error("product terms not forced low in test");

  comb_return_a: assert property (
    (ce_i && state_reg == PRPO_ST_TEST && !test_i)
    |=> (((io_o ^ $past(comb_exp)) & $past(comb_msk)) == '0))
    else $error("combinatorial output did not recover after test");

  latch_lost_a: assert property (
    (ce_i && state_reg == PRPO_ST_TEST) |=> (lat_reg == '0))
    else $error("latch content survived test unexpectedly");

  test_suspend_a: assert property (
    (ce_i && state_reg == PRPO_ST_TEST && test_i && !preload_i && !clr_hit && !set_hit)
    |=> $stable(mc_reg))
    else $error("registers clocked during observe");

  freeze_a: assert property (
    !ce_i |=> ($stable(state_reg) && $stable(mc_reg) && $stable(io_o)))
    else $error("state moved with clock enable low");
endmodule

//--- inc/prpo_pkg.sv
// constants and types for the power-up clear and the preload/observe test logic
// assumes a single 125 MHz clock and a synchronous power-detect reset
package prpo_pkg;
  // clock rate in MHz and the printed power-up clear limit in microseconds
  localparam int PRPO_CLK_MHZ = 125;
  localparam int PRPO_T_PR_US = 10;
  // longest time, so the cycle count rounds down (exact here)
  localparam int PRPO_PR_CYC = (PRPO_T_PR_US * PRPO_CLK_MHZ);
  // power-up timer width, wide enough for the clear window
  localparam int PRPO_CNT_W = 11;
  // default number of macrocells and the widest array the logic serves
  localparam int PRPO_NCELL_DEF = 16;
  localparam int PRPO_NCELL_MAX = 64;
  // value every flip-flop takes at power-up
  localparam logic PRPO_REG_RST = 1'b0;
  // one-hot operating states
  typedef enum logic [2:0] {
    PRPO_ST_PUR = 3'b001,
    PRPO_ST_RUN = 3'b010,
    PRPO_ST_TEST = 3'b100
  } prpo_state_t;
endpackage

//--- inc/prpo_tmr_if.sv
// carrier between the core and its power-up clear timer
// assumes both ends sit on mclk_i
`timescale 1ns/1ps
interface prpo_tmr_if;
  logic ce; // clock enable passed down to the timer
  logic done; // clear window has run out
  modport ctl (output ce, input done);
  modport tmr (input ce, output done);
endinterface

//--- rtl/prpo_pur_timer.sv
// counts out the power-up clear window after the power-detect reset
// assumes sys_rst_i marks supply rise and is synchronous to mclk_i
`timescale 1ns/1ps
module prpo_pur_timer
  import prpo_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  prpo_tmr_if.tmr tmr
);
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [PRPO_CNT_W-1:0] LAST = PRPO_CNT_W'(PRPO_PR_CYC - 1);
  logic [PRPO_CNT_W-1:0] cnt_reg; // cycles spent clearing
  logic [PRPO_CNT_W-1:0] cnt_next;

  // window end is a level so the core cannot miss it
  assign tmr.done = (cnt_reg == LAST);

  // next count: stop at the end, never wrap
  always_comb begin
    cnt_next = cnt_reg;
    if (!tmr.done) begin
      cnt_next = cnt_reg + PRPO_CNT_W'(1);
    end
  end

  // register only; frozen while the enable is low
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
    end else if (tmr.ce) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

//--- verification/prpo_tester.sv
// tester model: drives clock enable, test mode and preload data
// assumes the core samples its pins on rising mclk_i
`timescale 1ns/1ps
module prpo_tester #(
  parameter int NCELL = 8
) (
  input wire logic mclk_i,
  output logic ce_o,
  output logic test_o,
  output logic preload_o,
  output logic [NCELL-1:0] io_o
);
  ////////////////////////////////////////////////////////////////////////////
  // idle: no enabled edges, test off
  initial begin
    ce_o = 1'b0;
    test_o = 1'b0;
    preload_o = 1'b0;
    io_o = '0;
  end
  // edges held back
  // enable stays low until the inputs have settled for n cycles
  task automatic settle(input int n);
    @(negedge mclk_i);
    ce_o = 1'b0;
    repeat (n) @(negedge mclk_i);
    ce_o = 1'b1;
  endtask
  // freeze or resume clocking
  task automatic hold(input logic run);
    @(negedge mclk_i);
    ce_o = run;
  endtask
  // load from pins
  // callers pick values that leave clear/preset quiet, except two scenarios
  task automatic load(input logic [NCELL-1:0] v);
    @(negedge mclk_i);
    test_o = 1'b1;
    preload_o = 1'b1;
    io_o = v;
    repeat (3) @(negedge mclk_i);
  endtask
  // observe registers
  // pins handed to the device; our stale value is inverted, not kept
  task automatic observe();
    preload_o = 1'b0;
    io_o = ~io_o;
  endtask
  // leave test mode
  task automatic leave();
    @(negedge mclk_i);
    test_o = 1'b0;
  endtask
endmodule

//--- verification/prpo_core_bench.sv
// self-checking bench for the power-up clear and preload/observe core
// assumes prpo_tester plays the programmer on the pins
`timescale 1ns/1ps
module prpo_core_bench;
  import prpo_pkg::*;
  localparam int NC = 8;
  localparam logic [NC-1:0] POL = 8'h0f; // low nibble inverted
  localparam logic [NC-1:0] OE = 8'h55; // half the pins programmed off
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i, test_i, preload_i, ready_o, test_act_o;
  logic [NC-1:0] io_i, io_o, io_oe_n_o, lat_o;
  logic [NC-1:0] pterm_i = 8'hff; // terms all high so any leak shows
  logic [NC-1:0] oe_cfg = OE; // programmed enables, changed on test exit
  // clear/preset wiring: register 0 clears cell 7, register 1 presets cell 6
  logic [NC-1:0] clr_src = 8'h01;
  logic [NC-1:0] clr_dst = 8'h80;
  logic [NC-1:0] set_src = 8'h02;
  logic [NC-1:0] set_dst = 8'h40;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #4 mclk_i = ~mclk_i;
  prpo_core #(.NCELL(NC)) prpo_core_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .test_i(test_i),
    .preload_i(preload_i), .pterm_i(pterm_i), .pol_cfg_i(POL),
    .comb_cfg_i(8'h30), .latch_cfg_i(8'h20), .oe_cfg_i(oe_cfg),
    .clr_src_i(clr_src), .clr_dst_i(clr_dst), .set_src_i(set_src), .set_dst_i(set_dst),
    .io_i(io_i), .io_o(io_o), .io_oe_n_o(io_oe_n_o), .lat_o(lat_o),
    .ready_o(ready_o), .test_act_o(test_act_o));
  prpo_tester #(.NCELL(NC)) prpo_tester_inst (
    .mclk_i(mclk_i), .ce_o(ce_i), .test_o(test_i), .preload_o(preload_i),
    .io_o(io_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [NC-1:0] got, input logic [NC-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // a hang ends the run as a failure
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // power-up: clear held, then the window counts only enabled cycles
  task automatic t_powerup();
    int n;
    repeat (20) @(negedge mclk_i);
    check(io_oe_n_o, 8'hff);
    check(io_o, 8'h00);
    sys_rst_i = 1'b0;
    prpo_tester_inst.settle(2);
    n = 0;
    while (ready_o !== 1'b1 && n < 1300) begin
      @(negedge mclk_i);
      n++;
    end
    check(8'((n >= 1245) && (n <= 1252)), 8'h01);
    // cell 4 is plain combinatorial and already shows its live term
    check(io_o, POL ^ 8'h10);
    check(io_oe_n_o, ~OE);
  endtask
  // preload then observe, expecting stored value exp
  task automatic t_load(input logic [NC-1:0] v, input logic [NC-1:0] exp);
    prpo_tester_inst.load(v);
    check(io_oe_n_o, 8'hff);
    check({7'h00, test_act_o}, 8'h01);
    prpo_tester_inst.observe();
    repeat (3) @(negedge mclk_i);
    check(io_oe_n_o, 8'h00);
    check(io_o, POL ^ exp);
  endtask
  // leave test: outputs and latch recompute from live terms
  task automatic t_leave();
    pterm_i = 8'h3c;
    // new enables only show once the observe override is gone
    oe_cfg = 8'hf0;
    prpo_tester_inst.leave();
    repeat (3) @(negedge mclk_i);
    check(io_o, POL ^ 8'h3c);
    check(io_oe_n_o, 8'h0f);
    check({7'h00, test_act_o}, 8'h00);
    check(lat_o, 8'h3c);
  endtask
  // frozen enable keeps outputs, then resumes
  task automatic t_freeze();
    prpo_tester_inst.hold(1'b0);
    pterm_i = 8'hc0;
    repeat (3) @(negedge mclk_i);
    check(io_o, POL ^ 8'h3c);
    prpo_tester_inst.hold(1'b1);
    repeat (3) @(negedge mclk_i);
    check(io_o, POL ^ 8'hc0);
  endtask
  // a second power-detect wins over a frozen enable
  task automatic t_rereset();
    prpo_tester_inst.hold(1'b0);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    check(io_oe_n_o, 8'hff);
    check(io_o, 8'h00);
    check({7'h00, ready_o}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    t_powerup();
    t_load(8'ha4, 8'ha4);
    t_load(8'h83, 8'h43);
    t_load(8'h81, 8'h01);
    t_leave();
    t_freeze();
    t_rereset();
    close_out();
  end
endmodule
